// ==== rtl/cam_addr_decode.sv ====
// cam_addr_decode: operand fetch, address forming and write-back per addressing mode
`default_nettype none
// How it works
// [RULE_01] source-immediate writes A, F, stack top or X
// [RULE_02] immediate arithmetic combines with destination register
// [RULE_03] source-direct reads byte-two address into A/X
// [RULE_04] source modes: named A/X is second source
// [RULE_05] source-indexed address is byte two plus X
// [RULE_06] five single-operand modes are two bytes long
// [RULE_07] destination-direct writes A/X to byte-two address
// [RULE_08] destination-direct arithmetic reads destination first
// [RULE_09] destination-indexed address byte two plus X, source A
// [RULE_10] destination-indexed arithmetic reads location, A unchanged
// [RULE_11] direct-immediate is three bytes, third is source
// [RULE_12] opcode alone picks RAM or register space
// [RULE_13] destination moves never read the destination
// [RULE_14] flags read at F7; set via OR/AND immediate
// [RULE_15] flag bit 4 selects register-space bank
// [RULE_16] user writes never change supervisory bit
module cam_addr_decode #(
  parameter int unsigned PC_W = 16
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // instruction issue from the sequencer
  input wire logic i_start,
  input wire cam_pkg::cam_mode_t i_mode,
  input wire cam_pkg::cam_reg_sel_t i_reg_sel,
  input wire cam_pkg::cam_alu_op_t i_alu_op,
  input wire logic i_reg_space,
  input wire logic [PC_W-1:0] i_pc,
  // supervisory state control from the core
  input wire logic i_super_set,
  input wire logic i_super_clr,
  // program memory port
  output logic o_pm_rd,
  output logic [PC_W-1:0] o_pm_addr,
  input wire logic [7:0] i_pm_rdata,
  // data port: RAM or register space
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic o_mem_space,
  output logic o_mem_bank,
  output logic [7:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  // status and core registers
  output logic o_busy,
  output logic o_done,
  output logic [1:0] o_len,
  output logic [7:0] o_acc,
  output logic [7:0] o_idx,
  output logic [7:0] o_flags,
  output logic [7:0] o_stack_top_ptr
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH1 = 3'b001,
    ST_OP1    = 3'b010,
    ST_FETCH2 = 3'b011,
    ST_OP2    = 3'b100,
    ST_MWAIT  = 3'b101,
    ST_EXEC   = 3'b110
  } cam_state_t;

  function automatic logic is_dest(input cam_pkg::cam_mode_t m);
    is_dest = (m == cam_pkg::CAM_DST_DIR) || (m == cam_pkg::CAM_DST_IDX) || (m == cam_pkg::CAM_DST_DIR_IMM);
  endfunction
  function automatic logic [1:0] instr_len(input cam_pkg::cam_mode_t m);
    instr_len = (m == cam_pkg::CAM_DST_DIR_IMM) ? cam_pkg::LEN_LONG : cam_pkg::LEN_SHORT;
  endfunction

  cam_state_t state_q;
  cam_pkg::cam_mode_t mode_q;
  cam_pkg::cam_reg_sel_t sel_q;
  cam_pkg::cam_alu_op_t op_q;
  logic space_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] op1_q;
  logic [7:0] op2_q;
  logic [7:0] acc_q;
  logic [7:0] idx_q;
  logic [7:0] stack_top_ptr_q;
  logic [7:0] flags_q;
  logic pm_rd_q;
  logic [PC_W-1:0] pm_addr_q;
  logic mem_rd_q;
  logic mem_wr_q;
  logic mem_space_q;
  logic mem_bank_q;
  logic [7:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic done_q;
  logic busy_q;
  logic [1:0] len_q;
  logic is_mov;
  logic [7:0] dir_addr;
  logic [7:0] idx_addr;
  logic [7:0] rd_val;
  logic [7:0] reg_val;
  logic [7:0] dst_src;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_carry;
  logic alu_zero;
  logic exec_imm;
  logic reg_wr;
  logic last_step;

  assign is_mov = (op_q == cam_pkg::CAM_OP_MOV);
  assign dir_addr = i_pm_rdata;
  assign idx_addr = 8'(i_pm_rdata + idx_q); // RULE_05 RULE_09
  assign exec_imm = (state_q == ST_OP1) && (mode_q == cam_pkg::CAM_SRC_IMM);
  assign reg_wr = exec_imm || ((state_q == ST_EXEC) && !is_dest(mode_q));
  // the step after which the instruction's results stand; done and busy both follow it
  assign last_step = exec_imm || (state_q == ST_EXEC) || ((state_q == ST_OP2) && is_mov)
    || ((state_q == ST_OP1) && is_dest(mode_q) && is_mov && (mode_q != cam_pkg::CAM_DST_DIR_IMM));
  // the flag register never reaches the bus; it answers at its own address
  assign rd_val = (space_q && (mem_addr_q == cam_pkg::FLAG_REG_ADDR)) ? flags_q : i_mem_rdata; // RULE_14
  assign reg_val = (sel_q == cam_pkg::CAM_REG_ACC) ? acc_q : (sel_q == cam_pkg::CAM_REG_IDX) ? idx_q
    : (sel_q == cam_pkg::CAM_REG_FLG) ? flags_q : stack_top_ptr_q;
  // source of destination modes: indexed always takes A, direct the named register, direct-immediate byte three
  assign dst_src = (mode_q == cam_pkg::CAM_DST_IDX) ? acc_q // RULE_09
    : (mode_q == cam_pkg::CAM_DST_DIR_IMM) ? op2_q // RULE_11
    : reg_val; // RULE_07
  // destination arithmetic takes the addressed location first, source arithmetic the named register
  assign alu_a = ((state_q == ST_EXEC) && is_dest(mode_q)) ? rd_val : reg_val; // RULE_04 RULE_08 RULE_10
  assign alu_b = (state_q != ST_EXEC) ? i_pm_rdata : is_dest(mode_q) ? dst_src : rd_val; // RULE_02 RULE_04
  cam_alu u_alu (
    .i_op(op_q),
    .i_a(alu_a),
    .i_b(alu_b),
    .o_res(alu_res),
    .o_carry(alu_carry),
    .o_zero(alu_zero)
  );

  // sequencing and operand capture
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      mode_q <= cam_pkg::CAM_SRC_IMM;
      sel_q <= cam_pkg::CAM_REG_ACC;
      op_q <= cam_pkg::CAM_OP_MOV;
      space_q <= 1'b0;
      pc_q <= '0;
      op1_q <= 8'h00;
      op2_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            state_q <= ST_FETCH1;
            mode_q <= i_mode;
            sel_q <= i_reg_sel;
            op_q <= i_alu_op;
            space_q <= i_reg_space; // RULE_12
            pc_q <= i_pc;
          end
        end
        ST_FETCH1: state_q <= ST_OP1;
        ST_OP1: begin
          op1_q <= i_pm_rdata;
          state_q <= last_step ? ST_IDLE : (mode_q == cam_pkg::CAM_DST_DIR_IMM) ? ST_FETCH2 : ST_MWAIT;
        end
        ST_FETCH2: state_q <= ST_OP2;
        ST_OP2: begin
          op2_q <= i_pm_rdata; // RULE_11
          state_q <= is_mov ? ST_IDLE : ST_MWAIT;
        end
        ST_MWAIT: state_q <= ST_EXEC;
        ST_EXEC: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // program memory fetches of operand bytes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pm_rd_q <= 1'b0;
      pm_addr_q <= '0;
    end else begin
      pm_rd_q <= 1'b0;
      if ((state_q == ST_IDLE) && i_start) begin
        pm_rd_q <= 1'b1;
        pm_addr_q <= PC_W'(i_pc + 1'b1);
      end else if ((state_q == ST_OP1) && (mode_q == cam_pkg::CAM_DST_DIR_IMM)) begin
        pm_rd_q <= 1'b1;
        pm_addr_q <= PC_W'(pc_q + 2'h2);
      end
    end
  end
  // data port: address forming, reads and write-backs
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_space_q <= 1'b0;
      mem_bank_q <= 1'b0;
      mem_addr_q <= 8'h00;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      if ((state_q == ST_OP1) && (mode_q != cam_pkg::CAM_SRC_IMM) && (mode_q != cam_pkg::CAM_DST_DIR_IMM)) begin
        mem_space_q <= space_q; // RULE_12
        mem_bank_q <= space_q & flags_q[cam_pkg::FLAG_BANK_BIT]; // RULE_15
        if ((mode_q == cam_pkg::CAM_SRC_IDX) || (mode_q == cam_pkg::CAM_DST_IDX)) begin
          mem_addr_q <= idx_addr; // RULE_05 RULE_09
        end else begin
          mem_addr_q <= dir_addr; // RULE_03 RULE_07
        end
        if (is_dest(mode_q) && is_mov) begin
          mem_wr_q <= 1'b1; // RULE_13
          mem_wdata_q <= dst_src; // RULE_07 RULE_09
        end else begin
          mem_rd_q <= 1'b1; // RULE_03 RULE_08 RULE_10
        end
      end else if (state_q == ST_OP2) begin
        mem_space_q <= space_q;
        mem_bank_q <= space_q & flags_q[cam_pkg::FLAG_BANK_BIT]; // RULE_15
        mem_addr_q <= op1_q;
        if (is_mov) begin
          mem_wr_q <= 1'b1; // RULE_13
          mem_wdata_q <= i_pm_rdata;
        end else begin
          mem_rd_q <= 1'b1; // RULE_08
        end
      end else if ((state_q == ST_EXEC) && is_dest(mode_q)) begin
        mem_wr_q <= 1'b1; // RULE_08 RULE_10
        mem_wdata_q <= alu_res;
      end
    end
  end

  // working, offset and stack registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      acc_q <= cam_pkg::ACC_RESET;
      idx_q <= cam_pkg::IDX_RESET;
      stack_top_ptr_q <= cam_pkg::STACK_TOP_PTR_RESET;
    end else if (reg_wr) begin
      if (sel_q == cam_pkg::CAM_REG_ACC) acc_q <= alu_res; // RULE_01 RULE_03 RULE_04
      if (sel_q == cam_pkg::CAM_REG_IDX) idx_q <= alu_res; // RULE_01 RULE_03 RULE_04
      if (exec_imm && (sel_q == cam_pkg::CAM_REG_STACK_TOP_PTR)) stack_top_ptr_q <= alu_res; // RULE_01
    end
  end
  // flags: user writes masked, arithmetic updates zero, and ADD also updates carry
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      flags_q <= cam_pkg::FLAGS_RESET;
    end else begin
      if (exec_imm && (sel_q == cam_pkg::CAM_REG_FLG)) begin
        flags_q <= (alu_res & cam_pkg::FLAGS_USER_MASK) | (flags_q & ~cam_pkg::FLAGS_USER_MASK); // RULE_14 RULE_16
      end else if ((exec_imm || (state_q == ST_EXEC)) && !is_mov) begin
        flags_q[cam_pkg::FLAG_ZERO_BIT] <= alu_zero;
        if (op_q == cam_pkg::CAM_OP_ADD) begin
          flags_q[cam_pkg::FLAG_CARRY_BIT] <= alu_carry;
        end
      end
      // only the core moves the supervisory bit; set wins over clear
      if (i_super_set) begin
        flags_q[cam_pkg::FLAG_SUPER_BIT] <= 1'b1; // RULE_16
      end else if (i_super_clr) begin
        flags_q[cam_pkg::FLAG_SUPER_BIT] <= 1'b0;
      end
    end
  end

  // completion, busy and instruction length; busy is a flop so the output carries no decode
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
      len_q <= cam_pkg::LEN_SHORT;
    end else begin
      done_q <= last_step;
      if ((state_q == ST_IDLE) && i_start) begin
        busy_q <= 1'b1;
        len_q <= instr_len(i_mode); // RULE_06 RULE_11
      end else if (last_step) begin
        busy_q <= 1'b0;
      end
    end
  end
  assign o_pm_rd = pm_rd_q;
  assign o_pm_addr = pm_addr_q;
  assign o_mem_rd = mem_rd_q;
  assign o_mem_wr = mem_wr_q;
  assign o_mem_space = mem_space_q;
  assign o_mem_bank = mem_bank_q;
  assign o_mem_addr = mem_addr_q;
  assign o_mem_wdata = mem_wdata_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_len = len_q;
  assign o_acc = acc_q;
  assign o_idx = idx_q;
  assign o_flags = flags_q;
  assign o_stack_top_ptr = stack_top_ptr_q;
  sequence s_issue;
    (state_q == ST_IDLE) && i_start;
  endsequence
  a_len_short: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_06
    s_issue and (i_mode != cam_pkg::CAM_DST_DIR_IMM) |=> (o_len == 2'h2))
    else $error("two-byte mode did not report length two");
  a_len_long: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_11
    s_issue and (i_mode == cam_pkg::CAM_DST_DIR_IMM) |=> (o_len == 2'h3) ##2 o_pm_rd ##[1:4] o_done)
    else $error("three-byte mode length or second fetch wrong");
  a_done_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_06
    s_issue |=> o_pm_rd ##[2:6] o_done)
    else $error("instruction did not complete in time");
  a_idx_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_05
    (state_q == ST_OP1) && (mode_q == cam_pkg::CAM_SRC_IDX)
    |=> o_mem_rd && (o_mem_addr == 8'($past(i_pm_rdata) + $past(idx_q))))
    else $error("indexed source address is not operand plus offset");
  a_dir_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_03
    (state_q == ST_OP1) && (mode_q == cam_pkg::CAM_SRC_DIR) |=> o_mem_rd && (o_mem_addr == $past(i_pm_rdata)))
    else $error("direct source address is not the operand byte");
  a_move_no_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_13
    (state_q == ST_OP1) && is_dest(mode_q) && is_mov && (mode_q != cam_pkg::CAM_DST_DIR_IMM)
    |=> o_mem_wr && !o_mem_rd && o_done)
    else $error("destination move read its destination");
  a_dest_keeps_acc: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_10
    (state_q == ST_EXEC) && is_dest(mode_q) |=> o_mem_wr && $stable(acc_q) && (o_mem_wdata == $past(alu_res)))
    else $error("destination arithmetic altered the working register");
  a_super_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_16
    !i_super_set && !i_super_clr |=> $stable(flags_q[cam_pkg::FLAG_SUPER_BIT]))
    else $error("supervisory bit changed without the core");
  a_bank_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_15
    (o_mem_rd || o_mem_wr) && o_mem_space && !$past(exec_imm) |-> (o_mem_bank == flags_q[cam_pkg::FLAG_BANK_BIT]))
    else $error("register-space bank does not follow the flag bit");
endmodule
`default_nettype wire

// ==== rtl/cam_pkg.sv ====
// cam_pkg: shared constants and types for the operand addressing logic
`default_nettype none
package cam_pkg;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] FLAG_REG_ADDR = 8'hF7;
  localparam int unsigned FLAG_GIE_BIT = 0;
  localparam int unsigned FLAG_ZERO_BIT = 1;
  localparam int unsigned FLAG_CARRY_BIT = 2;
  localparam int unsigned FLAG_SUPER_BIT = 3;
  localparam int unsigned FLAG_BANK_BIT = 4;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  // bits that user code may write; reserved and supervisory bits excluded
  localparam logic [7:0] FLAGS_USER_MASK = 8'h17;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [7:0] STACK_TOP_PTR_RESET = 8'h00;
  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;

  typedef enum logic [2:0] {
    CAM_SRC_IMM     = 3'b000,
    CAM_SRC_DIR     = 3'b001,
    CAM_SRC_IDX     = 3'b010,
    CAM_DST_DIR     = 3'b011,
    CAM_DST_IDX     = 3'b100,
    CAM_DST_DIR_IMM = 3'b101
  } cam_mode_t;

  typedef enum logic [1:0] {
    CAM_REG_ACC = 2'b00,
    CAM_REG_IDX = 2'b01,
    CAM_REG_FLG = 2'b10,
    CAM_REG_STACK_TOP_PTR = 2'b11
  } cam_reg_sel_t;

  typedef enum logic [2:0] {
    CAM_OP_MOV = 3'b000,
    CAM_OP_ADD = 3'b001,
    CAM_OP_OR  = 3'b010,
    CAM_OP_AND = 3'b011,
    CAM_OP_XOR = 3'b100
  } cam_alu_op_t;
endpackage
`default_nettype wire

// ==== rtl/cam_alu.sv ====
// cam_alu: combinational second-source combiner for the addressing logic
`default_nettype none
module cam_alu (
  // operation and operands
  input wire cam_pkg::cam_alu_op_t i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  // result and flags
  output logic [7:0] o_res,
  output logic o_carry,
  output logic o_zero
);
  logic [8:0] sum;

  always_comb begin
    sum = {1'b0, i_a} + {1'b0, i_b};
    o_carry = 1'b0;
    case (i_op)
      cam_pkg::CAM_OP_ADD: begin
        o_res = sum[7:0];
        o_carry = sum[8];
      end
      cam_pkg::CAM_OP_OR: o_res = i_a | i_b;
      cam_pkg::CAM_OP_AND: o_res = i_a & i_b;
      cam_pkg::CAM_OP_XOR: o_res = i_a ^ i_b;
      default: o_res = i_b;
    endcase
    o_zero = (o_res == 8'h00);
  end
endmodule
`default_nettype wire

// ==== verification/cam_mem_model.sv ====
// cam_mem_model: program memory, data RAM and banked register space behind the addressing logic
`default_nettype none
module cam_mem_model #(
  parameter int unsigned PC_W = 16
) (
  // clock
  input wire logic i_mclk,
  // program port
  input wire logic i_pm_rd,
  input wire logic [PC_W-1:0] i_pm_addr,
  output logic [7:0] o_pm_rdata,
  // data port
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic i_mem_space,
  input wire logic i_mem_bank,
  input wire logic [7:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pm [0:255];
  // ram at 0, register bank 0 at 256, bank 1 at 512
  logic [7:0] dm [0:767];
  int n_rd = 0;
  int loc;
  initial begin
    o_pm_rdata = 8'h00;
    o_mem_rdata = 8'h00;
  end
  assign loc = i_mem_space ? 256 + 256 * int'(i_mem_bank) + int'(i_mem_addr) : int'(i_mem_addr);
  // data is valid only in the cycle after a strobe; otherwise it toggles so stale use shows
  always @(posedge i_mclk) begin
    o_pm_rdata <= i_pm_rd ? pm[i_pm_addr[7:0]] : ~o_pm_rdata;
    o_mem_rdata <= i_mem_rd ? dm[loc] : ~o_mem_rdata;
    if (i_mem_rd) n_rd <= n_rd + 1;
    if (i_mem_wr) dm[loc] <= i_mem_wdata;
  end
endmodule
`default_nettype wire

// ==== verification/cam_addr_decode_tb.sv ====
// cam_addr_decode_tb: self-checking scenarios for the operand addressing logic
`default_nettype none
module cam_addr_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk = 0, i_rst_n = 0, i_start = 0, i_reg_space = 0, i_super_set = 0, i_super_clr = 0;
  cam_pkg::cam_mode_t i_mode = cam_pkg::CAM_SRC_IMM;
  cam_pkg::cam_reg_sel_t i_reg_sel = cam_pkg::CAM_REG_ACC;
  cam_pkg::cam_alu_op_t i_alu_op = cam_pkg::CAM_OP_MOV;
  logic [15:0] i_pc = 16'h0000, o_pm_addr;
  logic [7:0] i_pm_rdata, i_mem_rdata, o_mem_addr, o_mem_wdata, o_acc, o_idx, o_flags, o_stack_top_ptr;
  logic o_pm_rd, o_mem_rd, o_mem_wr, o_mem_space, o_mem_bank, o_busy, o_done;
  logic [1:0] o_len;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  logic [7:0] pc = 8'h10;
  cam_addr_decode #(.PC_W(16)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start), .i_mode(i_mode),
    .i_reg_sel(i_reg_sel), .i_alu_op(i_alu_op), .i_reg_space(i_reg_space), .i_pc(i_pc),
    .i_super_set(i_super_set), .i_super_clr(i_super_clr), .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr),
    .i_pm_rdata(i_pm_rdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_space(o_mem_space),
    .o_mem_bank(o_mem_bank), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
    .o_busy(o_busy), .o_done(o_done), .o_len(o_len), .o_acc(o_acc), .o_idx(o_idx), .o_flags(o_flags),
    .o_stack_top_ptr(o_stack_top_ptr));
  cam_mem_model #(.PC_W(16)) mdl (.i_mclk(i_mclk), .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr),
    .o_pm_rdata(i_pm_rdata), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr), .i_mem_space(o_mem_space),
    .i_mem_bank(o_mem_bank), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

  always #50 i_mclk = ~i_mclk;
  // whole run is well under a thousand cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk2(input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  // one instruction, operand bytes placed after the opcode address
  task automatic issue(input cam_pkg::cam_mode_t m, input cam_pkg::cam_reg_sel_t r, input cam_pkg::cam_alu_op_t o,
                       input logic s, input logic [7:0] b1, input logic [7:0] b2 = 8'hA5);
    int n;
    mdl.pm[pc + 8'h01] = b1;
    mdl.pm[pc + 8'h02] = b2;
    @(posedge i_mclk);
    #1;
    i_start = 1;
    i_mode = m;
    i_reg_sel = r;
    i_alu_op = o;
    i_reg_space = s;
    i_pc = {8'h00, pc};
    @(posedge i_mclk);
    #1;
    i_start = 0;
    chk2(2'h1, {1'b0, o_busy});
    n = 0;
    while (o_done !== 1'b1 && n < 20) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk2(2'h1, {1'b0, o_done});
    chk2(2'h0, {1'b0, o_busy});
    chk2(m == cam_pkg::CAM_DST_DIR_IMM ? cam_pkg::LEN_LONG : cam_pkg::LEN_SHORT, o_len);
    pc = pc + 8'h03;
    // let the memory take the write strobed with done
    @(posedge i_mclk);
    #1;
  endtask

  task automatic strobe_super(input logic set);
    @(posedge i_mclk);
    #1;
    i_super_set = set;
    i_super_clr = ~set;
    @(posedge i_mclk);
    #1;
    i_super_set = 0;
    i_super_clr = 0;
  endtask

  task automatic t_reset();
    chk8(cam_pkg::ACC_RESET, o_acc);
    chk8(cam_pkg::IDX_RESET, o_idx);
    chk8(cam_pkg::FLAGS_RESET, o_flags);
    chk8(cam_pkg::STACK_TOP_PTR_RESET, o_stack_top_ptr);
    chk2(cam_pkg::LEN_SHORT, o_len);
    $display("test reset done");
  endtask

  task automatic t_src_imm();
    issue(cam_pkg::CAM_SRC_IMM, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_MOV, 0, 8'h37);
    chk8(8'h37, o_acc);
    issue(cam_pkg::CAM_SRC_IMM, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_ADD, 0, 8'h0C);
    chk8(8'h43, o_acc);
    chk8(8'h00, o_flags);
    issue(cam_pkg::CAM_SRC_IMM, cam_pkg::CAM_REG_IDX, cam_pkg::CAM_OP_MOV, 0, 8'h05);
    chk8(8'h05, o_idx);
    issue(cam_pkg::CAM_SRC_IMM, cam_pkg::CAM_REG_STACK_TOP_PTR, cam_pkg::CAM_OP_MOV, 0, 8'h80);
    chk8(8'h80, o_stack_top_ptr);
    $display("test source immediate done");
  endtask

  task automatic t_flags();
    mdl.dm[256 + 247] = 8'hAA;
    issue(cam_pkg::CAM_SRC_IMM, cam_pkg::CAM_REG_FLG, cam_pkg::CAM_OP_OR, 0, 8'h10);
    chk8(8'h10, o_flags);
    issue(cam_pkg::CAM_DST_DIR_IMM, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_MOV, 1, 8'h08, 8'h06);
    chk8(8'h06, mdl.dm[512 + 8]);
    issue(cam_pkg::CAM_SRC_DIR, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_MOV, 1, 8'hF7);
    chk8(8'h10, o_acc);
    strobe_super(1);
    chk8(8'h18, o_flags);
    // clearing bit 3 from user code must not take effect
    issue(cam_pkg::CAM_SRC_IMM, cam_pkg::CAM_REG_FLG, cam_pkg::CAM_OP_AND, 0, 8'hF7);
    chk8(8'h18, o_flags);
    strobe_super(0);
    chk8(8'h10, o_flags);
    issue(cam_pkg::CAM_SRC_IMM, cam_pkg::CAM_REG_FLG, cam_pkg::CAM_OP_AND, 0, 8'hEF);
    chk8(8'h00, o_flags);
    $display("test flags done");
  endtask

  task automatic t_src_mem();
    mdl.dm[7] = 8'h20;
    mdl.dm[13] = 8'hC3;
    mdl.dm[256 + 13] = 8'h5A;
    mdl.dm[98] = 8'h03;
    issue(cam_pkg::CAM_SRC_DIR, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_ADD, 0, 8'h07);
    chk8(8'h30, o_acc);
    issue(cam_pkg::CAM_SRC_IDX, cam_pkg::CAM_REG_IDX, cam_pkg::CAM_OP_MOV, 1, 8'h08);
    chk8(8'h5A, o_idx);
    issue(cam_pkg::CAM_SRC_IDX, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_ADD, 0, 8'h08);
    chk8(8'h33, o_acc);
    $display("test source memory done");
  endtask

  task automatic t_dst();
    int r;
    mdl.dm[48] = 8'h11;
    mdl.dm[10] = 8'h01;
    mdl.dm[49] = 8'hFF;
    issue(cam_pkg::CAM_DST_DIR, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_ADD, 0, 8'h30);
    chk8(8'h44, mdl.dm[48]);
    chk8(8'h33, o_acc);
    r = mdl.n_rd;
    issue(cam_pkg::CAM_DST_DIR, cam_pkg::CAM_REG_IDX, cam_pkg::CAM_OP_MOV, 1, 8'h40);
    chk8(8'h5A, mdl.dm[256 + 64]);
    chk8(8'(r), 8'(mdl.n_rd));
    // index sum wraps inside the 8-bit space
    issue(cam_pkg::CAM_DST_IDX, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_ADD, 0, 8'hB0);
    chk8(8'h34, mdl.dm[10]);
    chk8(8'h33, o_acc);
    issue(cam_pkg::CAM_DST_IDX, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_MOV, 0, 8'h10);
    chk8(8'h33, mdl.dm[106]);
    issue(cam_pkg::CAM_DST_DIR_IMM, cam_pkg::CAM_REG_ACC, cam_pkg::CAM_OP_ADD, 0, 8'h31, 8'h05);
    chk8(8'h04, mdl.dm[49]);
    $display("test destination done");
  endtask

  initial begin
    repeat (3) @(posedge i_mclk);
    #1;
    i_rst_n = 1;
    t_reset();
    t_src_imm();
    t_flags();
    t_src_mem();
    t_dst();
    stop_test();
  end
endmodule
`default_nettype wire
